// ===== bench/scfe_exec_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module scfe_exec_monitor
    import scfe_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire scfe_pkg::scfe_op_t i_op,
    input wire logic [scfe_pkg::XLEN-1:0] i_pc,
    input wire logic [scfe_pkg::XLEN-1:0] i_rs_a,
    input wire logic [scfe_pkg::IMMW-1:0] i_imm,
    input wire logic [scfe_pkg::JIMMW-1:0] i_jimm,
    input wire logic i_mem_idle,
    input wire logic o_ready,
    input wire logic o_redirect,
    input wire logic [scfe_pkg::XLEN-1:0] o_target,
    input wire logic o_squash,
    input wire logic o_link_we,
    input wire logic [scfe_pkg::XLEN-1:0] o_link,
    input wire logic o_ls_hold,
    input wire logic [scfe_pkg::XLEN-1:0] o_status,
    input wire logic [scfe_pkg::XLEN-1:0] o_elink
);
    // Accepted instruction
    wire logic tk = i_valid && o_ready;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////
    a_redirect_kills_next:
        assert property (o_redirect |-> o_squash) else $error("no squash");
    a_call_link:
        assert property (tk && i_op == SCFE_OP_CALL |=> o_link_we && o_link == $past(i_pc) + INSN_BYTES
            && o_target[27:0] == {$past(i_jimm), 2'b00}) else $error("call wrong");
    a_callr_link:
        assert property (tk && i_op == SCFE_OP_CALLR |=> o_redirect && o_target == $past(i_rs_a)
            && o_link == $past(i_pc) + INSN_BYTES) else $error("callr wrong");
    a_ret_target:
        assert property (tk && i_op == SCFE_OP_RET |=> o_redirect && o_target == $past(o_link))
            else $error("ret wrong");
    a_jmp_keeps_link:
        assert property (tk && i_op == SCFE_OP_JMP |=> o_target == $past(i_rs_a) && !o_link_we && $stable(o_link))
            else $error("jmp wrong");
    a_branch_offset:
        assert property (tk && i_op == SCFE_OP_BR |=> o_redirect && o_target == $past(i_pc)
            + {{16{$past(i_imm[15])}}, $past(i_imm)}) else $error("br wrong");
    a_trap_entry:
        assert property (tk && i_op == SCFE_OP_TRAP |=> o_redirect && o_target == EXC_VECTOR
            && o_status[1:0] == 2'b00 && o_elink == $past(i_pc) + INSN_BYTES) else $error("trap wrong");
    a_sync_holds:
        assert property (tk && i_op == SCFE_OP_SYNC |=> !o_ready && o_ls_hold) else $error("no hold");
    a_sync_release:
        assert property (o_ls_hold && i_mem_idle |=> o_ready && !o_ls_hold) else $error("no release");
endmodule
bind scfe_exec scfe_exec_monitor mon (.i_clk, .i_rst, .i_valid, .i_op, .i_pc, .i_rs_a, .i_imm, .i_jimm,
    .i_mem_idle, .o_ready, .o_redirect, .o_target, .o_squash, .o_link_we, .o_link, .o_ls_hold, .o_status, .o_elink);
`default_nettype wire

// ===== bench/shift_and_control_flow_exec_tb.sv
`timescale 1ns/1ns
`default_nettype none
module shift_and_control_flow_exec_tb;
    import scfe_pkg::*;
    logic i_clk = 0, i_rst = 1, i_valid = 0, i_mem_idle = 1;
    scfe_op_t i_op = SCFE_OP_NONE;
    logic [31:0] i_pc = '0, i_rs_a = '0, i_rs_b = '0;
    logic [15:0] i_imm = '0;
    logic [25:0] i_jimm = '0;
    logic [2:0] i_ctl_sel = '0;
    logic o_ready, o_wb_en, o_link_we, o_redirect, o_squash, o_prefetch_flush, o_ls_hold, o_in_break;
    logic [31:0] o_wb_data, o_target, o_cache_addr, o_status, o_link, o_elink, o_blink;
    logic [2:0] o_cache_op;
    int error_cnt = 0, comparisons = 0;
    // 250 MHz core clock
    always #2 i_clk = ~i_clk;
    scfe_exec dut (.i_clk, .i_rst, .i_valid, .i_op, .i_pc, .i_rs_a, .i_rs_b, .i_imm, .i_jimm, .i_ctl_sel,
        .i_mem_idle, .o_ready, .o_wb_en, .o_wb_data, .o_link_we, .o_redirect, .o_target, .o_squash,
        .o_prefetch_flush, .o_cache_op, .o_cache_addr, .o_ls_hold, .o_status, .o_link, .o_elink, .o_blink,
        .o_in_break);
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // One instruction; results read after the answer edge
    task automatic go(input scfe_op_t op, input logic [31:0] pc = '0, a = '0, b = '0,
        input logic [15:0] imm = '0, input logic [25:0] jimm = '0, input logic [2:0] sel = '0);
        @(posedge i_clk);
        i_valid <= 1'b1;
        i_op <= op;
        i_pc <= pc;
        i_rs_a <= a;
        i_rs_b <= b;
        i_imm <= imm;
        i_jimm <= jimm;
        i_ctl_sel <= sel;
        @(posedge i_clk);
        i_valid <= 1'b0;
        #1;
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // Count 0x24 keeps 4, immediate gives 7: a swapped source shows
    task automatic t_shift();
        scfe_op_t ops[9] = '{SCFE_OP_ROL, SCFE_OP_ROLI, SCFE_OP_ROR, SCFE_OP_SLL, SCFE_OP_SLLI,
            SCFE_OP_SRL, SCFE_OP_SRLI, SCFE_OP_SRA, SCFE_OP_SRAI};
        logic [31:0] v, e;
        logic [4:0] s;
        v = 32'h8000_00f1;
        foreach (ops[k])
        begin
            s = (ops[k] inside {SCFE_OP_ROLI, SCFE_OP_SLLI, SCFE_OP_SRLI, SCFE_OP_SRAI}) ? 5'h07 : 5'h04;
            case (ops[k])
                SCFE_OP_ROL, SCFE_OP_ROLI: e = (v << s) | (v >> (32 - s));
                SCFE_OP_ROR: e = (v >> s) | (v << (32 - s));
                SCFE_OP_SLL, SCFE_OP_SLLI: e = v << s;
                SCFE_OP_SRL, SCFE_OP_SRLI: e = v >> s;
                default: e = $signed(v) >>> s;
            endcase
            go(ops[k], 32'h0, v, 32'h0000_0024, 16'h0fe7);
            chk(o_wb_data, e);
            chk(32'(o_wb_en), 32'h1);
        end
        $display("t_shift done");
    endtask
    // Signed and unsigned orders split on -1 vs 1
    task automatic t_cond();
        logic [9:0] t1 = 10'b0101101010, t2 = 10'b0011001101;
        for (int k = 0; k < 10; k++)
        begin
            go(scfe_op_t'(6'h10 + k), 32'h100, 32'hffff_ffff, 32'h1, 16'hfff8);
            chk(32'(o_redirect), 32'(t1[k]));
            chk(32'(o_squash), 32'(t1[k]));
            if (t1[k])
                chk(o_target, 32'h0000_00f8);
            go(scfe_op_t'(6'h10 + k), 32'h100, 32'h5, 32'h5, 16'hfff8);
            chk(32'(o_redirect), 32'(t2[k]));
        end
        $display("t_cond done");
    endtask
    task automatic t_jump();
        go(SCFE_OP_CALL, 32'h3000_0010, 0, 0, 0, 26'h000_0123);
        chk(o_target, 32'h3000_048c);
        chk(o_link, 32'h3000_0014);
        chk(32'(o_squash), 32'h1);
        go(SCFE_OP_RET);
        chk(o_target, 32'h3000_0014);
        go(SCFE_OP_CALLR, 32'h50, 32'h4000);
        chk(o_target, 32'h0000_4000);
        chk(32'(o_link_we), 32'h1);
        go(SCFE_OP_JMP, 32'h60, 32'h6000);
        chk(o_target, 32'h0000_6000);
        chk(o_link, 32'h0000_0054);
        go(SCFE_OP_JMPI, 32'h7000_0000, 0, 0, 0, 26'h000_0040);
        chk(o_target, 32'h7000_0100);
        go(SCFE_OP_BR, 32'h100, 0, 0, 16'hfff8);
        chk(o_target, 32'h0000_00f8);
        go(SCFE_OP_FLUSHP, 32'h80);
        chk({o_target[30:0], o_prefetch_flush}, {31'h0000_0084, 1'b1});
        $display("t_jump done");
    endtask
    // Saved status must return unchanged
    task automatic t_exc();
        go(SCFE_OP_WRCTL, 0, 32'h3, 0, 0, 0, CR_STATUS);
        chk(o_status, 32'h3);
        go(SCFE_OP_TRAP, 32'h200);
        chk(o_target, EXC_VECTOR);
        chk(o_elink, 32'h204);
        go(SCFE_OP_RDCTL, 0, 0, 0, 0, 0, CR_ESTAT);
        chk(o_wb_data, 32'h3);
        go(SCFE_OP_ERET);
        chk(o_target, 32'h204);
        chk(o_status, 32'h3);
        go(SCFE_OP_BREAK, 32'h300);
        chk({o_target[30:0], o_in_break}, {BRK_VECTOR[30:0], 1'b1});
        go(SCFE_OP_BRET);
        chk({o_target[30:0], o_in_break}, {31'h304, 1'b0});
        $display("t_exc done");
    endtask
    // All cache codes, then a barrier refusing work until memory idles
    task automatic t_mem();
        for (int k = 0; k < 6; k++)
        begin
            go(scfe_op_t'(6'h20 + k), 0, 32'h1000, 0, 16'hfffc);
            chk(32'(o_cache_op), k + 1);
            chk(o_cache_addr, 32'h0000_0ffc);
        end
        @(posedge i_clk);
        i_mem_idle <= 1'b0;
        go(SCFE_OP_SYNC);
        chk({o_ready, o_ls_hold}, 2'b01);
        go(SCFE_OP_SLLI, 0, 32'h1, 0, 16'h1);
        chk({o_wb_en, o_ready}, 2'b00);
        @(posedge i_clk);
        i_mem_idle <= 1'b1;
        repeat (2) @(posedge i_clk);
        #1;
        chk({o_ready, o_ls_hold}, 2'b10);
        $display("t_mem done");
    endtask
    ////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (10) @(posedge i_clk);
        i_rst <= 1'b0;
        t_shift();
        t_cond();
        t_jump();
        t_exc();
        t_mem();
        print_verdict();
    end
    // Watchdog; run needs under 1000 cycles
    initial
    begin
        #20000;
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire

// ===== verilog/scfe_brcmp.sv
`timescale 1ns/1ns
`default_nettype none
module scfe_brcmp
    import scfe_pkg::*;
#(
    parameter int W = 32
)
(
    input wire logic [W-1:0] i_a,
    input wire logic [W-1:0] i_b,
    input wire scfe_pkg::scfe_op_t i_op,
    output logic o_take
);
    logic eq;
    logic lts;
    logic ltu;

    ////////////////////////////////////////////////////////////////////////
    // Operand a compared against b; non-branch codes never take
    always_comb
    begin
        eq = (i_a == i_b);
        lts = ($signed(i_a) < $signed(i_b));
        ltu = (i_a < i_b);
        unique case (i_op)
            SCFE_OP_BEQ: o_take = eq; // see [RULE14]
            SCFE_OP_BNE: o_take = ~eq;
            SCFE_OP_BGE: o_take = ~lts;
            SCFE_OP_BGEU: o_take = ~ltu;
            SCFE_OP_BGT: o_take = ~lts & ~eq;
            SCFE_OP_BGTU: o_take = ~ltu & ~eq;
            SCFE_OP_BLE: o_take = lts | eq;
            SCFE_OP_BLEU: o_take = ltu | eq;
            SCFE_OP_BLT: o_take = lts;
            SCFE_OP_BLTU: o_take = ltu;
            default: o_take = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// ===== verilog/scfe_exec.sv
`timescale 1ns/1ns
`default_nettype none
module scfe_exec
    import scfe_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire scfe_pkg::scfe_op_t i_op,
    input wire logic [scfe_pkg::XLEN-1:0] i_pc,
    input wire logic [scfe_pkg::XLEN-1:0] i_rs_a,
    input wire logic [scfe_pkg::XLEN-1:0] i_rs_b,
    input wire logic [scfe_pkg::IMMW-1:0] i_imm,
    input wire logic [scfe_pkg::JIMMW-1:0] i_jimm,
    input wire logic [scfe_pkg::CRW-1:0] i_ctl_sel,
    input wire logic i_mem_idle,
    output logic o_ready,
    output logic o_wb_en,
    output logic [scfe_pkg::XLEN-1:0] o_wb_data,
    output logic o_link_we,
    output logic o_redirect,
    output logic [scfe_pkg::XLEN-1:0] o_target,
    output logic o_squash,
    output logic o_prefetch_flush,
    output logic [scfe_pkg::CACHE_OPW-1:0] o_cache_op,
    output logic [scfe_pkg::XLEN-1:0] o_cache_addr,
    output logic o_ls_hold,
    output logic [scfe_pkg::XLEN-1:0] o_status,
    output logic [scfe_pkg::XLEN-1:0] o_link,
    output logic [scfe_pkg::XLEN-1:0] o_elink,
    output logic [scfe_pkg::XLEN-1:0] o_blink,
    output logic o_in_break
);
    import scfe_pkg::*;

    logic [XLEN-1:0] status_q;
    logic [XLEN-1:0] estat_q;
    logic [XLEN-1:0] bstat_q;
    logic [XLEN-1:0] link_reg_q;
    logic [XLEN-1:0] exception_link_reg_q;
    logic [XLEN-1:0] brk_link_q;
    logic in_break_q;
    scfe_state_t state_q;
    logic [XLEN-1:0] seq_pc;
    logic [XLEN-1:0] simm;
    logic [XLEN-1:0] rel_tgt;
    logic [XLEN-1:0] abs_tgt;
    logic [XLEN-1:0] sh_res;
    logic [SHW-1:0] sh_amt;
    logic sh_left;
    logic sh_rot;
    logic sh_arith;
    logic is_shift;
    logic take;
    logic fire;
    logic ctl_rd;
    logic [XLEN-1:0] ctl_val;

    ////////////////////////////////////////////////////////////////////////
    // Operand decode for the shift unit
    always_comb
    begin
        is_shift = 1'b1;
        sh_left = 1'b0;
        sh_rot = 1'b0;
        sh_arith = 1'b0;
        sh_amt = i_rs_b[SHW-1:0]; // see [RULE6]
        unique case (i_op)
            SCFE_OP_ROL: begin sh_left = 1'b1; sh_rot = 1'b1; end
            SCFE_OP_ROLI: begin sh_left = 1'b1; sh_rot = 1'b1; sh_amt = i_imm[SHW-1:0]; end // see [RULE1]
            SCFE_OP_ROR: sh_rot = 1'b1; // see [RULE2]
            SCFE_OP_SLL: sh_left = 1'b1;
            SCFE_OP_SLLI: begin sh_left = 1'b1; sh_amt = i_imm[SHW-1:0]; end // see [RULE5]
            SCFE_OP_SRL: sh_left = 1'b0;
            SCFE_OP_SRLI: sh_amt = i_imm[SHW-1:0];
            SCFE_OP_SRA: sh_arith = 1'b1;
            SCFE_OP_SRAI: begin sh_arith = 1'b1; sh_amt = i_imm[SHW-1:0]; end
            default: is_shift = 1'b0;
        endcase
    end

    scfe_shifter #(
        .W(XLEN),
        .CW(SHW)
    ) u_shift (
        .i_val(i_rs_a),
        .i_amt(sh_amt),
        .i_left(sh_left),
        .i_rot(sh_rot),
        .i_arith(sh_arith),
        .o_res(sh_res)
    );

    scfe_brcmp #(
        .W(XLEN)
    ) u_cmp (
        .i_a(i_rs_a),
        .i_b(i_rs_b),
        .i_op(i_op),
        .o_take(take)
    );

    ////////////////////////////////////////////////////////////////////////
    // Target arithmetic; offsets are relative to the branch itself
    always_comb
    begin
        seq_pc = i_pc + INSN_BYTES;
        simm = {{(XLEN-IMMW){i_imm[IMMW-1]}}, i_imm};
        rel_tgt = i_pc + simm; // see [RULE13]
        abs_tgt = {i_pc[XLEN-1:XLEN-4], i_jimm, 2'b00}; // see [RULE8] see [RULE12]
        ctl_rd = (i_op == SCFE_OP_RDCTL);
        unique case (i_ctl_sel)
            CR_STATUS: ctl_val = status_q;
            CR_ESTAT: ctl_val = estat_q;
            CR_BSTAT: ctl_val = bstat_q;
            default: ctl_val = '0;
        endcase
    end

    // Barrier stalls acceptance, so nothing can slip past it
    assign o_ready = (state_q == SCFE_RUN);
    assign fire = i_valid & (state_q == SCFE_RUN);

    ////////////////////////////////////////////////////////////////////////
    // Barrier: drain outstanding memory traffic before new loads/stores
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state_q <= SCFE_RUN;
            o_ls_hold <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                SCFE_RUN:
                begin
                    if (fire && i_op == SCFE_OP_SYNC)
                    begin
                        state_q <= SCFE_DRAIN; // see [RULE22]
                        o_ls_hold <= 1'b1;
                    end
                end
                SCFE_DRAIN:
                begin
                    if (i_mem_idle)
                    begin
                        state_q <= SCFE_RUN;
                        o_ls_hold <= 1'b0;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result writeback to the general register file
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_wb_en <= 1'b0;
            o_wb_data <= '0;
        end
        else
        begin
            o_wb_en <= fire & (is_shift | ctl_rd);
            o_wb_data <= ctl_rd ? ctl_val : sh_res; // see [RULE19]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Redirects; squash kills the sequential successor, no delay slot
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_redirect <= 1'b0;
            o_target <= RESET_PC;
            o_squash <= 1'b0;
        end
        else
        begin
            o_redirect <= 1'b0;
            o_squash <= 1'b0;
            if (fire)
            begin
                unique case (i_op)
                    SCFE_OP_CALL, SCFE_OP_JMPI:
                    begin
                        o_redirect <= 1'b1; // see [RULE7]
                        o_squash <= 1'b1;
                        o_target <= abs_tgt;
                    end
                    SCFE_OP_CALLR, SCFE_OP_JMP:
                    begin
                        o_redirect <= 1'b1; // see [RULE9] see [RULE11]
                        o_squash <= 1'b1;
                        o_target <= i_rs_a;
                    end
                    SCFE_OP_RET:
                    begin
                        o_redirect <= 1'b1;
                        o_squash <= 1'b1;
                        o_target <= link_reg_q; // see [RULE10]
                    end
                    SCFE_OP_BR:
                    begin
                        o_redirect <= 1'b1;
                        o_squash <= 1'b1;
                        o_target <= rel_tgt;
                    end
                    SCFE_OP_BEQ, SCFE_OP_BNE, SCFE_OP_BGE, SCFE_OP_BGEU, SCFE_OP_BGT,
                    SCFE_OP_BGTU, SCFE_OP_BLE, SCFE_OP_BLEU, SCFE_OP_BLT, SCFE_OP_BLTU:
                    begin
                        o_redirect <= take;
                        o_squash <= take; // see [RULE15]
                        o_target <= rel_tgt;
                    end
                    SCFE_OP_TRAP:
                    begin
                        o_redirect <= 1'b1;
                        o_squash <= 1'b1;
                        o_target <= EXC_VECTOR; // see [RULE16]
                    end
                    SCFE_OP_ERET:
                    begin
                        o_redirect <= 1'b1;
                        o_squash <= 1'b1;
                        o_target <= exception_link_reg_q; // see [RULE17]
                    end
                    SCFE_OP_BREAK:
                    begin
                        o_redirect <= 1'b1;
                        o_squash <= 1'b1;
                        o_target <= BRK_VECTOR; // see [RULE18]
                    end
                    SCFE_OP_BRET:
                    begin
                        o_redirect <= 1'b1;
                        o_squash <= 1'b1;
                        o_target <= brk_link_q;
                    end
                    SCFE_OP_FLUSHP:
                    begin
                        o_redirect <= 1'b1;
                        o_squash <= 1'b1;
                        o_target <= seq_pc; // see [RULE21]
                    end
                    default:
                    begin
                        o_redirect <= 1'b0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Return-address registers
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            link_reg_q <= '0;
            o_link_we <= 1'b0;
            exception_link_reg_q <= '0;
            brk_link_q <= '0;
        end
        else
        begin
            o_link_we <= fire & (i_op == SCFE_OP_CALL || i_op == SCFE_OP_CALLR);
            if (fire && (i_op == SCFE_OP_CALL || i_op == SCFE_OP_CALLR))
            begin
                link_reg_q <= seq_pc; // see [RULE8] see [RULE9]
            end
            if (fire && i_op == SCFE_OP_TRAP)
            begin
                exception_link_reg_q <= seq_pc; // see [RULE16]
            end
            if (fire && i_op == SCFE_OP_BREAK)
            begin
                brk_link_q <= seq_pc;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status and saved copies; entry masks interrupts and leaves user mode
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            status_q <= STATUS_RESET;
            estat_q <= STATUS_RESET;
            bstat_q <= STATUS_RESET;
            in_break_q <= 1'b0;
        end
        else if (fire)
        begin
            unique case (i_op)
                SCFE_OP_TRAP:
                begin
                    estat_q <= status_q; // see [RULE16]
                    status_q[ST_PIE] <= 1'b0;
                    status_q[ST_USER] <= 1'b0;
                end
                SCFE_OP_ERET: status_q <= estat_q; // see [RULE17]
                SCFE_OP_BREAK:
                begin
                    bstat_q <= status_q; // see [RULE18]
                    status_q[ST_PIE] <= 1'b0;
                    status_q[ST_USER] <= 1'b0;
                    in_break_q <= 1'b1;
                end
                SCFE_OP_BRET:
                begin
                    status_q <= bstat_q;
                    in_break_q <= 1'b0;
                end
                SCFE_OP_WRCTL:
                begin
                    unique case (i_ctl_sel)
                        CR_STATUS: status_q <= i_rs_a; // see [RULE19]
                        CR_ESTAT: estat_q <= i_rs_a;
                        CR_BSTAT: bstat_q <= i_rs_a;
                        default: status_q <= status_q;
                    endcase
                end
                default: status_q <= status_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cache maintenance requests, one-cycle pulse with the address
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_cache_op <= CO_NONE;
            o_cache_addr <= '0;
        end
        else
        begin
            o_cache_addr <= i_rs_a + simm;
            o_cache_op <= CO_NONE;
            if (fire)
            begin
                unique case (i_op)
                    SCFE_OP_FLUSHD: o_cache_op <= CO_FLUSHD; // see [RULE20]
                    SCFE_OP_FLUSHDA: o_cache_op <= CO_FLUSHDA;
                    SCFE_OP_FLUSHI: o_cache_op <= CO_FLUSHI;
                    SCFE_OP_INITD: o_cache_op <= CO_INITD;
                    SCFE_OP_INITDA: o_cache_op <= CO_INITDA;
                    SCFE_OP_INITI: o_cache_op <= CO_INITI;
                    default: o_cache_op <= CO_NONE;
                endcase
            end
        end
    end

    // Debug pulse for flushp; redirect carries the real work
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_prefetch_flush <= 1'b0;
        end
        else
        begin
            o_prefetch_flush <= fire & (i_op == SCFE_OP_FLUSHP); // see [RULE21]
        end
    end

    assign o_status = status_q;
    assign o_link = link_reg_q;
    assign o_elink = exception_link_reg_q;
    assign o_blink = brk_link_q;
    assign o_in_break = in_break_q;
endmodule
`default_nettype wire

// ===== verilog/scfe_pkg.sv
// Function
// [RULE1] Rotate left; count from register or immediate field.
// [RULE2] Rotate right with register count; no immediate form exists.
// [RULE3] Logical shifts left and right fill vacated bits with zero.
// [RULE4] Arithmetic right shifts copy the sign bit into vacated high bits.
// [RULE5] Immediate shifts count from immediate field; register shifts from a register.
// [RULE6] Register counts use only their five low bits, giving 0 to 31.
// [RULE7] Jumps and calls redirect with no delay slot; next instruction not executed.
// [RULE8] Immediate call jumps to absolute immediate target and writes link register.
// [RULE9] Register call jumps to register address and writes link register.
// [RULE10] Subroutine return continues at the address held in the link register.
// [RULE11] Register jump continues at register address, link register untouched.
// [RULE12] Immediate jump continues at absolute address from immediate field.
// [RULE13] Relative branch target is own address plus signed offset.
// [RULE14] Conditional branches compare two registers: eq, ne, signed and unsigned order.
// [RULE15] Taken conditional branches have no delay slot.
// [RULE16] Software exception saves status and return address, enters exception handler.
// [RULE17] Exception return restores status and resumes at exception link address.
// [RULE18] Debug break entry and return, for debugging tools only.
// [RULE19] Control register read to general register and write from general register.
// [RULE20] Data and instruction cache line and address flush and initialise operations.
// [RULE21] Prefetch discard drops every prefetched instruction from the pipeline.
// [RULE22] Memory barrier holds later loads and stores until earlier operations complete.
package scfe_pkg;
    localparam int XLEN = 32;
    localparam int SHW = 5;
    localparam int IMMW = 16;
    localparam int JIMMW = 26;
    localparam int OPW = 6;
    localparam int CRW = 3;
    localparam int CACHE_OPW = 3;
    localparam logic [XLEN-1:0] RESET_PC = 32'h0000_0000;
    localparam logic [XLEN-1:0] EXC_VECTOR = 32'h0000_0020;
    localparam logic [XLEN-1:0] BRK_VECTOR = 32'h0000_0100;
    localparam logic [XLEN-1:0] INSN_BYTES = 32'h0000_0004;
    localparam logic [XLEN-1:0] STATUS_RESET = 32'h0000_0000;
    // Status bits cleared on exception or break entry
    localparam int ST_PIE = 0;
    localparam int ST_USER = 1;
    // Control register indices
    localparam logic [CRW-1:0] CR_STATUS = 3'h0;
    localparam logic [CRW-1:0] CR_ESTAT = 3'h1;
    localparam logic [CRW-1:0] CR_BSTAT = 3'h2;
    // Cache maintenance codes
    localparam logic [CACHE_OPW-1:0] CO_NONE = 3'h0;
    localparam logic [CACHE_OPW-1:0] CO_FLUSHD = 3'h1;
    localparam logic [CACHE_OPW-1:0] CO_FLUSHDA = 3'h2;
    localparam logic [CACHE_OPW-1:0] CO_FLUSHI = 3'h3;
    localparam logic [CACHE_OPW-1:0] CO_INITD = 3'h4;
    localparam logic [CACHE_OPW-1:0] CO_INITDA = 3'h5;
    localparam logic [CACHE_OPW-1:0] CO_INITI = 3'h6;
    typedef enum logic [OPW-1:0] {
        SCFE_OP_NONE = 6'h00,
        SCFE_OP_ROL = 6'h01,
        SCFE_OP_ROLI = 6'h02,
        SCFE_OP_ROR = 6'h03,
        SCFE_OP_SLL = 6'h04,
        SCFE_OP_SLLI = 6'h05,
        SCFE_OP_SRL = 6'h06,
        SCFE_OP_SRLI = 6'h07,
        SCFE_OP_SRA = 6'h08,
        SCFE_OP_SRAI = 6'h09,
        SCFE_OP_CALL = 6'h0a,
        SCFE_OP_CALLR = 6'h0b,
        SCFE_OP_RET = 6'h0c,
        SCFE_OP_JMP = 6'h0d,
        SCFE_OP_JMPI = 6'h0e,
        SCFE_OP_BR = 6'h0f,
        SCFE_OP_BEQ = 6'h10,
        SCFE_OP_BNE = 6'h11,
        SCFE_OP_BGE = 6'h12,
        SCFE_OP_BGEU = 6'h13,
        SCFE_OP_BGT = 6'h14,
        SCFE_OP_BGTU = 6'h15,
        SCFE_OP_BLE = 6'h16,
        SCFE_OP_BLEU = 6'h17,
        SCFE_OP_BLT = 6'h18,
        SCFE_OP_BLTU = 6'h19,
        SCFE_OP_TRAP = 6'h1a,
        SCFE_OP_ERET = 6'h1b,
        SCFE_OP_BREAK = 6'h1c,
        SCFE_OP_BRET = 6'h1d,
        SCFE_OP_RDCTL = 6'h1e,
        SCFE_OP_WRCTL = 6'h1f,
        SCFE_OP_FLUSHD = 6'h20,
        SCFE_OP_FLUSHDA = 6'h21,
        SCFE_OP_FLUSHI = 6'h22,
        SCFE_OP_INITD = 6'h23,
        SCFE_OP_INITDA = 6'h24,
        SCFE_OP_INITI = 6'h25,
        SCFE_OP_FLUSHP = 6'h26,
        SCFE_OP_SYNC = 6'h27
    } scfe_op_t;
    typedef enum logic [0:0] {
        SCFE_RUN = 1'b0,
        SCFE_DRAIN = 1'b1
    } scfe_state_t;
endpackage

// ===== verilog/scfe_shifter.sv
`timescale 1ns/1ns
`default_nettype none
module scfe_shifter
    import scfe_pkg::*;
#(
    parameter int W = 32,
    parameter int CW = 5
)
(
    input wire logic [W-1:0] i_val,
    input wire logic [CW-1:0] i_amt,
    input wire logic i_left,
    input wire logic i_rot,
    input wire logic i_arith,
    output logic [W-1:0] o_res
);
    logic [2*W-1:0] ext;
    logic [2*W-1:0] wide;
    logic [W-1:0] rev_in;
    logic [W-1:0] rev_out;
    logic fill;

    ////////////////////////////////////////////////////////////////////////
    // Left ops reuse the right shifter on bit-reversed data to save area
    always_comb
    begin
        for (int k = 0; k < W; k++)
        begin
            rev_in[k] = i_val[W-1-k];
        end
        fill = i_arith & ~i_left & i_val[W-1]; // see [RULE4]
        if (i_rot)
        begin
            ext = {i_left ? rev_in : i_val, i_left ? rev_in : i_val}; // see [RULE1] see [RULE2]
        end
        else
        begin
            ext = {{W{fill}}, i_left ? rev_in : i_val}; // see [RULE3]
        end
        wide = ext >> i_amt;
        for (int k = 0; k < W; k++)
        begin
            rev_out[k] = wide[W-1-k];
        end
        o_res = i_left ? rev_out : wide[W-1:0];
    end
endmodule
`default_nettype wire
